//--- rtl/e1ar_pkg.sv
/*
 * e1ar_pkg: register map, field positions, reset values, timing and bus
 * carrier types for the e1 alarm and performance-monitor event bank.
 * assumes a single 10 MHz core clock and an 8-bit plain register port.
 */
package e1ar_pkg;

    // register byte offsets
    localparam logic [7:0] ALARM_STATUS_OFS  = 8'h00B9;
    localparam logic [7:0] ALARM_IRQ_EN_OFS  = 8'h00BA;
    localparam logic [7:0] ALARM_FLAGS_OFS   = 8'h00BB;
    localparam logic [7:0] ALARM_CRIT_OFS    = 8'h00BC;
    localparam logic [7:0] PM_UPD_CTRL_OFS   = 8'h00C2;
    localparam logic [7:0] PM_IRQ_EN_LO_OFS  = 8'h00C3;
    localparam logic [7:0] PM_IRQ_EN_HI_OFS  = 8'h00C4;
    localparam logic [7:0] PM_FLAGS_LO_OFS   = 8'h00C5;
    localparam logic [7:0] PM_FLAGS_HI_OFS   = 8'h00C6;

    // field positions
    localparam int RMA_BIT        = 3;
    localparam int AIS_BIT        = 2;
    localparam int RAI_BIT        = 1;
    localparam int RED_BIT        = 0;
    localparam int AIS_CRIT_BIT   = 5;
    localparam int RAI_CRIT_BIT   = 4;
    localparam int SNAP_TRIG_BIT  = 1;
    localparam int SNAP_AUTO_BIT  = 0;
    localparam int LCV_BIT        = 0;

    // reset values
    localparam logic [7:0] REG_RESET_VAL = 8'h0000;

    // alarm detection figures
    localparam int          AIS_WINDOW_BITS = 512;
    localparam logic [1:0]  AIS_ZERO_LIMIT  = 2'h3;
    localparam logic [2:0]  RAI_ONES_NEEDED = 3'h4;
    localparam logic [1:0]  RMA_ONES_NEEDED = 2'h3;

    // timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int RED_PERSIST_MS = 100;
    localparam int SNAP_PERIOD_S  = 1;
    localparam int RED_CYCLES     = (RED_PERSIST_MS * 1000000) / CLK_PERIOD_NS;
    localparam int SNAP_CYCLES    = (SNAP_PERIOD_S * 1000000000) / CLK_PERIOD_NS;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic       wrStb;
        logic       rdStb;
    } e1ar_bus_req_t;

    // received line events
    typedef struct packed {
        logic basicSync;
        logic mfSync;
        logic lineBitVld;
        logic lineBit;
        logic aBitVld;
        logic aBit;
        logic yBitVld;
        logic yBit;
    } e1ar_line_t;

endpackage : e1ar_pkg

//--- rtl/e1ar_event_regs.sv
/*
 * e1ar_event_regs: alarm detectors, change flags, overflow flags, counter
 * snapshot control and interrupt gating for an e1 receive framer.
 * assumes line events and counter overflow pulses synchronous to core_clk.
 */
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// R1: flag multiframe, all-ones and far-end alarm changes on any status toggle.
// R2: flag sync-loss alarm on rise or fall; flag stays zero while steady.
// R3: host writing one clears a flag; writing zero leaves it.
// R4: criterion 0: fewer than 3 zeros per 512 bits, out of sync, declares.
// R5: criterion 1: two consecutive windows needed to declare and to clear.
// R6: far-end criterion 0: four ones declare, one zero clears.
// R7: far-end criterion 1: single one declares, single zero clears.
// R8: rising edge of snapshot trigger copies all counters at once.
// R9: per-second bit set refreshes counter copies every second.
// R10: eight low overflow flags reach interrupt only when enabled.
// R11: line-code overflow flag reaches interrupt only when enabled.
// R12: counter overflow pulses set matching low overflow flags.
// R13: line-code counter overflow sets its flag, else flag stays zero.
// R14: each alarm change flag gated onto interrupt by its enable.
// R15: sync-loss alarm after 100ms out of sync; clears after 100ms in sync.
// R16: in multiframe sync, three Y ones declare; single zero clears.
// R17: interrupt pin low while any enabled flag set, released when cleared.
module e1ar_event_regs
    import e1ar_pkg::*;
#(
    parameter int RED_CYC  = e1ar_pkg::RED_CYCLES,
    parameter int SNAP_CYC = e1ar_pkg::SNAP_CYCLES
)(
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    arst_n,
    // register port
    input  wire e1ar_pkg::e1ar_bus_req_t regReq,
    output logic [7:0]                   regRdData,
    // line events and counter overflows
    input  wire e1ar_pkg::e1ar_line_t    lineIn,
    input  wire logic [7:0]              cntOvfLo,
    input  wire logic                    cntOvfLcv,
    // outputs
    output logic [3:0]                   alarmState,
    output logic                         counterSnapshot,
    output logic                         irq_n
);
    import e1ar_pkg::*;

    logic        rstMeta_q;
    logic        rstN_q;
    logic [7:0]  rdData_q;
    logic [1:0]  crit_q;
    logic [1:0]  pmCtl_q;
    logic [3:0]  alarmEn_q;
    logic [3:0]  alarmFlag_q;
    logic [3:0]  alarmFlag_d;
    logic [7:0]  pmEnLo_q;
    logic        pmEnHi_q;
    logic [7:0]  pmFlagLo_q;
    logic [7:0]  pmFlagLo_d;
    logic        pmFlagHi_q;
    logic        pmFlagHi_d;
    logic [3:0]  status_q;
    logic [3:0]  status_d;
    logic [8:0]  winCnt_q;
    logic [1:0]  zeroCnt_q;
    logic        prevLow_q;
    logic [2:0]  raiCnt_q;
    logic [1:0]  rmaCnt_q;
    logic [23:0] redCnt_q;
    logic [23:0] secCnt_q;
    logic        trigPrev_q;
    logic        snap_q;
    logic        irqN_q;
    logic        winEnd;
    logic        winLow;
    logic [1:0]  zeroNext;
    logic        wrHit;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstMeta_q <= 1'b0;
            rstN_q    <= 1'b0;
        end
        else
        begin
            rstMeta_q <= 1'b1;
            rstN_q    <= rstMeta_q;
        end
    end

    assign wrHit = regReq.wrStb;

    // writable control registers
    always_ff @(posedge core_clk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            crit_q    <= 2'h0;
            pmCtl_q   <= 2'h0;
            alarmEn_q <= 4'h0;
            pmEnLo_q  <= REG_RESET_VAL;
            pmEnHi_q  <= 1'b0;
        end
        else if (wrHit)
        begin
            if (regReq.addr == ALARM_CRIT_OFS)
                crit_q <= {regReq.wrData[AIS_CRIT_BIT], regReq.wrData[RAI_CRIT_BIT]};
            else if (regReq.addr == PM_UPD_CTRL_OFS)
                pmCtl_q <= {regReq.wrData[SNAP_TRIG_BIT], regReq.wrData[SNAP_AUTO_BIT]};
            else if (regReq.addr == ALARM_IRQ_EN_OFS)
                alarmEn_q <= regReq.wrData[3:0];
            else if (regReq.addr == PM_IRQ_EN_LO_OFS)
                pmEnLo_q <= regReq.wrData;
            else if (regReq.addr == PM_IRQ_EN_HI_OFS)
                pmEnHi_q <= regReq.wrData[LCV_BIT];
        end
    end

    // read data, one cycle after the strobe, zero when unmapped
    always_ff @(posedge core_clk or negedge rstN_q)
    begin
        if (!rstN_q)
            rdData_q <= REG_RESET_VAL;
        else if (regReq.rdStb)
        begin
            if (regReq.addr == ALARM_STATUS_OFS)
                rdData_q <= {4'h0, status_q};
            else if (regReq.addr == ALARM_IRQ_EN_OFS)
                rdData_q <= {4'h0, alarmEn_q};
            else if (regReq.addr == ALARM_FLAGS_OFS)
                rdData_q <= {4'h0, alarmFlag_q};
            else if (regReq.addr == ALARM_CRIT_OFS)
                rdData_q <= {2'h0, crit_q, 4'h0};
            else if (regReq.addr == PM_UPD_CTRL_OFS)
                rdData_q <= {6'h00, pmCtl_q};
            else if (regReq.addr == PM_IRQ_EN_LO_OFS)
                rdData_q <= pmEnLo_q;
            else if (regReq.addr == PM_IRQ_EN_HI_OFS)
                rdData_q <= {7'h00, pmEnHi_q};
            else if (regReq.addr == PM_FLAGS_LO_OFS)
                rdData_q <= pmFlagLo_q;
            else if (regReq.addr == PM_FLAGS_HI_OFS)
                rdData_q <= {7'h00, pmFlagHi_q};
            else
                rdData_q <= REG_RESET_VAL;
        end
        else
            rdData_q <= REG_RESET_VAL;
    end

    // all-ones window: zero count saturates at the limit
    assign winEnd   = lineIn.lineBitVld && (winCnt_q == 9'(AIS_WINDOW_BITS - 1));
    assign zeroNext = (lineIn.lineBitVld && !lineIn.lineBit && zeroCnt_q != AIS_ZERO_LIMIT)
                    ? zeroCnt_q + 2'h1 : zeroCnt_q;
    assign winLow   = zeroNext < AIS_ZERO_LIMIT;

    always_ff @(posedge core_clk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            winCnt_q  <= 9'h000;
            zeroCnt_q <= 2'h0;
            prevLow_q <= 1'b0;
        end
        else if (lineIn.lineBitVld)
        begin
            winCnt_q <= winEnd ? 9'h000 : winCnt_q + 9'h001;
            zeroCnt_q <= winEnd ? 2'h0 : zeroNext;
            if (winEnd)
                prevLow_q <= winLow;
        end
    end

    // alarm detectors feeding the status bits
    always_comb
    begin
        status_d = status_q;
        if (winEnd)
        begin
            if (!crit_q[1])
            begin
                // a quiet window in sync neither declares nor clears
                if (winLow && !lineIn.basicSync)
                    status_d[AIS_BIT] = 1'b1; // R4
                else if (!winLow)
                    status_d[AIS_BIT] = 1'b0; // R4
            end
            else if (winLow && prevLow_q)
                status_d[AIS_BIT] = 1'b1; // R5
            else if (!winLow && !prevLow_q)
                status_d[AIS_BIT] = 1'b0; // R5
        end
        if (lineIn.aBitVld)
        begin
            if (!lineIn.aBit)
                status_d[RAI_BIT] = 1'b0; // R6 R7
            else if (crit_q[0])
                status_d[RAI_BIT] = 1'b1; // R7
            else if (raiCnt_q + 3'h1 >= RAI_ONES_NEEDED)
                status_d[RAI_BIT] = 1'b1; // R6
        end
        if (lineIn.mfSync && lineIn.yBitVld)
        begin
            if (!lineIn.yBit)
                status_d[RMA_BIT] = 1'b0; // R16
            else if (rmaCnt_q >= RMA_ONES_NEEDED - 2'h1)
                status_d[RMA_BIT] = 1'b1; // R16
        end
        // toggle only while the disagreement still holds on the last count
        if (redCnt_q == 24'(RED_CYC - 1) && lineIn.basicSync == status_q[RED_BIT])
            status_d[RED_BIT] = !status_q[RED_BIT]; // R15
    end

    // run counters for far-end, multiframe and sync-loss persistence
    always_ff @(posedge core_clk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            raiCnt_q <= 3'h0;
            rmaCnt_q <= 2'h0;
            redCnt_q <= 24'h00_0000;
            status_q <= 4'h0;
        end
        else
        begin
            status_q <= status_d;
            if (lineIn.aBitVld)
                raiCnt_q <= !lineIn.aBit ? 3'h0
                          : (raiCnt_q == RAI_ONES_NEEDED) ? raiCnt_q : raiCnt_q + 3'h1;
            if (!lineIn.mfSync)
                rmaCnt_q <= 2'h0;
            else if (lineIn.yBitVld)
                rmaCnt_q <= !lineIn.yBit ? 2'h0
                          : (rmaCnt_q == RMA_ONES_NEEDED) ? rmaCnt_q : rmaCnt_q + 2'h1;
            // counts while sync state disagrees with the alarm state
            if (lineIn.basicSync == status_q[RED_BIT] && redCnt_q != 24'(RED_CYC - 1))
                redCnt_q <= redCnt_q + 24'h00_0001; // R15
            else
                redCnt_q <= 24'h00_0000;
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_comb
    begin
        alarmFlag_d = alarmFlag_q;
        pmFlagLo_d  = pmFlagLo_q;
        pmFlagHi_d  = pmFlagHi_q;
        if (wrHit && regReq.addr == ALARM_FLAGS_OFS)
            alarmFlag_d = alarmFlag_q & ~regReq.wrData[3:0]; // R3
        if (wrHit && regReq.addr == PM_FLAGS_LO_OFS)
            pmFlagLo_d = pmFlagLo_q & ~regReq.wrData; // R3
        if (wrHit && regReq.addr == PM_FLAGS_HI_OFS)
            pmFlagHi_d = pmFlagHi_q & ~regReq.wrData[LCV_BIT]; // R3
        alarmFlag_d = alarmFlag_d | (status_d ^ status_q); // R1 R2
        pmFlagLo_d  = pmFlagLo_d | cntOvfLo; // R12
        pmFlagHi_d  = pmFlagHi_d | cntOvfLcv; // R13
    end

    always_ff @(posedge core_clk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            alarmFlag_q <= 4'h0;
            pmFlagLo_q  <= REG_RESET_VAL;
            pmFlagHi_q  <= 1'b0;
        end
        else
        begin
            alarmFlag_q <= alarmFlag_d;
            pmFlagLo_q  <= pmFlagLo_d;
            pmFlagHi_q  <= pmFlagHi_d;
        end
    end

    // counter snapshot: manual rising edge or once per second
    always_ff @(posedge core_clk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            trigPrev_q <= 1'b0;
            secCnt_q   <= 24'h00_0000;
            snap_q     <= 1'b0;
        end
        else
        begin
            trigPrev_q <= pmCtl_q[1];
            if (!pmCtl_q[0] || secCnt_q == 24'(SNAP_CYC - 1))
                secCnt_q <= 24'h00_0000;
            else
                secCnt_q <= secCnt_q + 24'h00_0001;
            snap_q <= (pmCtl_q[1] && !trigPrev_q) // R8
                   || (pmCtl_q[0] && secCnt_q == 24'(SNAP_CYC - 1)); // R9
        end
    end

    // active-low interrupt from enabled flags
    always_ff @(posedge core_clk or negedge rstN_q)
    begin
        if (!rstN_q)
            irqN_q <= 1'b1;
        else
            irqN_q <= !(|(alarmFlag_q & alarmEn_q) // R14 R17
                     || |(pmFlagLo_q & pmEnLo_q) // R10
                     || (pmFlagHi_q && pmEnHi_q)); // R11
    end

    assign regRdData       = rdData_q;
    assign alarmState      = status_q;
    assign counterSnapshot = snap_q;
    assign irq_n           = irqN_q;

    // checks
    AST_FLAG_ON_TOGGLE: assert property (@(posedge core_clk) disable iff (!rstN_q) // R1
        (status_q != $past(status_q)) |-> ((alarmFlag_q & (status_q ^ $past(status_q))) != 4'h0))
        else $error("alarm change not flagged");
    AST_RED_STEADY: assert property (@(posedge core_clk) disable iff (!rstN_q) // R2
        $rose(alarmFlag_q[RED_BIT]) |-> $changed(status_q[RED_BIT]))
        else $error("sync-loss flag set without change");
    AST_W1C: assert property (@(posedge core_clk) disable iff (!rstN_q) // R3
        (wrHit && regReq.addr == PM_FLAGS_LO_OFS && regReq.wrData[0] && !cntOvfLo[0])
        |=> !pmFlagLo_q[0])
        else $error("overflow flag not cleared");
    AST_AIS_I431: assert property (@(posedge core_clk) disable iff (!rstN_q) // R4
        (winEnd && !crit_q[1] && winLow && !lineIn.basicSync) |=> status_q[AIS_BIT])
        else $error("all-ones alarm not declared");
    AST_RAI_FAST: assert property (@(posedge core_clk) disable iff (!rstN_q) // R7
        (lineIn.aBitVld && crit_q[0]) |=> (status_q[RAI_BIT] == $past(lineIn.aBit)))
        else $error("far-end alarm does not follow bit");
    AST_RAI_ZERO: assert property (@(posedge core_clk) disable iff (!rstN_q) // R6
        (lineIn.aBitVld && !lineIn.aBit) |=> !status_q[RAI_BIT])
        else $error("far-end alarm not cleared");
    AST_SNAP_MANUAL: assert property (@(posedge core_clk) disable iff (!rstN_q) // R8
        (pmCtl_q[1] && !trigPrev_q) |=> counterSnapshot)
        else $error("manual snapshot missing");
    AST_OVF_SET: assert property (@(posedge core_clk) disable iff (!rstN_q) // R12
        (cntOvfLo != 8'h00) |=> ((pmFlagLo_q & $past(cntOvfLo)) == $past(cntOvfLo)))
        else $error("overflow not flagged");
    AST_LCV_SET: assert property (@(posedge core_clk) disable iff (!rstN_q) // R13
        cntOvfLcv |=> pmFlagHi_q)
        else $error("line-code overflow not flagged");
    AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (!rstN_q) // R10 R11 R14 R17
        ##1 (irq_n == !(|($past(alarmFlag_q) & $past(alarmEn_q)) || |($past(pmFlagLo_q)
        & $past(pmEnLo_q)) || ($past(pmFlagHi_q) && $past(pmEnHi_q)))))
        else $error("interrupt pin wrong");
    AST_RMA_SYNC: assert property (@(posedge core_clk) disable iff (!rstN_q) // R16
        (!lineIn.mfSync) |=> (status_q[RMA_BIT] == $past(status_q[RMA_BIT])))
        else $error("multiframe alarm moved out of sync");
    AST_RED_HOLD: assert property (@(posedge core_clk) disable iff (!rstN_q) // R15
        (redCnt_q == 24'h00_0000 && $past(redCnt_q) == 24'h00_0000)
        |-> $stable(status_q[RED_BIT]))
        else $error("sync-loss alarm moved early");
    AST_AIS_CLEAR: assert property (@(posedge core_clk) disable iff (!rstN_q) // R4
        (winEnd && !crit_q[1] && !winLow) |=> !status_q[AIS_BIT])
        else $error("all-ones alarm not cleared");
    AST_AIS_G775: assert property (@(posedge core_clk) disable iff (!rstN_q) // R5
        (winEnd && crit_q[1] && winLow && prevLow_q) |=> status_q[AIS_BIT])
        else $error("two-window all-ones alarm not declared");
    AST_RMA_ZERO: assert property (@(posedge core_clk) disable iff (!rstN_q) // R16
        (lineIn.mfSync && lineIn.yBitVld && !lineIn.yBit) |=> !status_q[RMA_BIT])
        else $error("multiframe alarm not cleared");
    AST_SNAP_IDLE: assert property (@(posedge core_clk) disable iff (!rstN_q) // R9
        (!pmCtl_q[0] && !(pmCtl_q[1] && !trigPrev_q)) |=> !counterSnapshot)
        else $error("snapshot without cause");
    COV_IRQ: cover property (@(posedge core_clk) disable iff (!rstN_q) $fell(irq_n));
    COV_AIS: cover property (@(posedge core_clk) disable iff (!rstN_q) $rose(status_q[AIS_BIT]));
    COV_SNAP: cover property (@(posedge core_clk) disable iff (!rstN_q) counterSnapshot);
    COV_RED: cover property (@(posedge core_clk) disable iff (!rstN_q) $rose(status_q[RED_BIT]));

endmodule : e1ar_event_regs

`default_nettype wire

//--- testbench/test_e1_alarm_perfmon_event_regs.sv
/*
 * test_e1_alarm_perfmon_event_regs: self-checking bench for the alarm and
 * performance-monitor event bank, driven through its plain register port.
 * assumes shortened sync-loss and per-second counts set at the instance.
 */
`timescale 1ns/10ps
`default_nettype none

module test_e1_alarm_perfmon_event_regs;
    import e1ar_pkg::*;

    localparam int RED_T  = 20;
    localparam int SNAP_T = 50;

    logic            core_clk;
    logic            arst_n;
    e1ar_bus_req_t   regReq;
    e1ar_line_t      lineIn;
    logic [7:0]      cntOvfLo;
    logic            cntOvfLcv;
    logic [7:0]      regRdData;
    logic [3:0]      alarmState;
    logic            counterSnapshot;
    logic            irq_n;
    int              badCount;
    int              cmpCount;
    int              snapCnt = 0;

    e1ar_event_regs #(.RED_CYC(RED_T), .SNAP_CYC(SNAP_T)) e1ar_event_regs_i (
        .core_clk        (core_clk),
        .arst_n          (arst_n),
        .regReq          (regReq),
        .regRdData       (regRdData),
        .lineIn          (lineIn),
        .cntOvfLo        (cntOvfLo),
        .cntOvfLcv       (cntOvfLcv),
        .alarmState      (alarmState),
        .counterSnapshot (counterSnapshot),
        .irq_n           (irq_n)
    );

    // free-running core clock, 100 ns period
    always #50 core_clk = ~core_clk;

    // counts snapshot pulses seen on the port
    always @(posedge core_clk)
    begin
        if (counterSnapshot === 1'b1)
            snapCnt++;
    end

    task automatic wrapUp();
        if (badCount == 0 && cmpCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrapUp

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            badCount++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one-cycle write strobe beside address and data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regReq.addr   <= a;
        regReq.wrData <= d;
        regReq.wrStb  <= 1'b1;
        @(posedge core_clk);
        regReq.wrStb  <= 1'b0;
    endtask : wr

    // read data stands in the cycle after the strobe only
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regReq.addr  <= a;
        regReq.rdStb <= 1'b1;
        @(posedge core_clk);
        regReq.rdStb <= 1'b0;
        #1 check(regRdData, exp);
    endtask : rd

    // interrupt pin settles two cycles after its cause
    task automatic irqChk(input logic exp);
        repeat (2) @(posedge core_clk);
        #1 check({7'h00, irq_n}, {7'h00, exp});
    endtask : irqChk

    task automatic stChk(input int idx, input logic exp);
        @(posedge core_clk);
        #1 check({7'h00, alarmState[idx]}, {7'h00, exp});
    endtask : stChk

    // kind 0 sends an A bit, kind 1 a Y bit
    task automatic sendBit(input int kind, input logic v);
        @(posedge core_clk);
        if (kind == 0)
        begin
            lineIn.aBitVld <= 1'b1;
            lineIn.aBit    <= v;
        end
        else
        begin
            lineIn.yBitVld <= 1'b1;
            lineIn.yBit    <= v;
        end
        @(posedge core_clk);
        lineIn.aBitVld <= 1'b0;
        lineIn.yBitVld <= 1'b0;
    endtask : sendBit

    // one fixed window with nz leading zeros
    task automatic win(input int nz);
        @(posedge core_clk);
        for (int i = 0; i < AIS_WINDOW_BITS; i++)
        begin
            lineIn.lineBitVld <= 1'b1;
            lineIn.lineBit    <= (i < nz) ? 1'b0 : 1'b1;
            @(posedge core_clk);
        end
        lineIn.lineBitVld <= 1'b0;
    endtask : win

    // watchdog well beyond the expected few thousand cycles
    initial
    begin
        #(30000 * 100);
        badCount++;
        wrapUp();
    end

    initial
    begin
        logic [7:0] m;
        int         s;
        logic [7:0] ofs [9];
        core_clk  = 1'b0;
        arst_n    = 1'b0;
        regReq    = '0;
        lineIn    = '0;
        lineIn.basicSync = 1'b1;
        cntOvfLo  = 8'h00;
        cntOvfLcv = 1'b0;
        badCount  = 0;
        cmpCount  = 0;
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        // reset values and an unmapped place
        ofs = '{ALARM_STATUS_OFS, ALARM_IRQ_EN_OFS, ALARM_FLAGS_OFS, ALARM_CRIT_OFS,
                PM_UPD_CTRL_OFS, PM_IRQ_EN_LO_OFS, PM_IRQ_EN_HI_OFS, PM_FLAGS_LO_OFS,
                PM_FLAGS_HI_OFS};
        foreach (ofs[i])
            rd(ofs[i], 8'h00);
        wr(8'h50, 8'hFF);
        rd(8'h50, 8'h00);
        check({7'h00, irq_n}, 8'h01);
        // far-end alarm, single-bit criterion
        wr(ALARM_CRIT_OFS, 8'h10);
        sendBit(0, 1'b1);
        stChk(RAI_BIT, 1'b1);
        rd(ALARM_FLAGS_OFS, 8'h02);
        wr(ALARM_FLAGS_OFS, 8'h00);
        rd(ALARM_FLAGS_OFS, 8'h02);
        wr(ALARM_FLAGS_OFS, 8'h02);
        rd(ALARM_FLAGS_OFS, 8'h00);
        sendBit(0, 1'b0);
        stChk(RAI_BIT, 1'b0);
        rd(ALARM_FLAGS_OFS, 8'h02);
        wr(ALARM_FLAGS_OFS, 8'hFF);
        // far-end alarm, four-bit criterion
        wr(ALARM_CRIT_OFS, 8'h00);
        repeat (3) sendBit(0, 1'b1);
        stChk(RAI_BIT, 1'b0);
        sendBit(0, 1'b1);
        stChk(RAI_BIT, 1'b1);
        sendBit(0, 1'b0);
        stChk(RAI_BIT, 1'b0);
        wr(ALARM_FLAGS_OFS, 8'hFF);
        // multiframe alarm ignored out of multiframe sync
        repeat (3) sendBit(1, 1'b1);
        stChk(RMA_BIT, 1'b0);
        @(posedge core_clk);
        lineIn.mfSync <= 1'b1;
        repeat (3) sendBit(1, 1'b1);
        stChk(RMA_BIT, 1'b1);
        rd(ALARM_FLAGS_OFS, 8'h08);
        sendBit(1, 1'b0);
        stChk(RMA_BIT, 1'b0);
        wr(ALARM_FLAGS_OFS, 8'hFF);
        // all-ones window while in sync does not declare
        win(0);
        stChk(AIS_BIT, 1'b0);
        // sync loss, then its interrupt gate
        @(posedge core_clk);
        lineIn.basicSync <= 1'b0;
        repeat (RED_T + 5) @(posedge core_clk);
        rd(ALARM_STATUS_OFS, 8'h01);
        rd(ALARM_FLAGS_OFS, 8'h01);
        irqChk(1'b1);
        wr(ALARM_IRQ_EN_OFS, 8'h01);
        irqChk(1'b0);
        wr(ALARM_IRQ_EN_OFS, 8'h00);
        irqChk(1'b1);
        win(0);
        stChk(AIS_BIT, 1'b1);
        win(3);
        stChk(AIS_BIT, 1'b0);
        rd(ALARM_FLAGS_OFS, 8'h05);
        wr(ALARM_FLAGS_OFS, 8'hFF);
        // two-window criterion
        wr(ALARM_CRIT_OFS, 8'h20);
        rd(ALARM_CRIT_OFS, 8'h20);
        win(0);
        stChk(AIS_BIT, 1'b0);
        win(2);
        stChk(AIS_BIT, 1'b1);
        win(3);
        stChk(AIS_BIT, 1'b1);
        win(5);
        stChk(AIS_BIT, 1'b0);
        @(posedge core_clk);
        lineIn.basicSync <= 1'b1;
        repeat (RED_T + 5) @(posedge core_clk);
        rd(ALARM_STATUS_OFS, 8'h00);
        rd(ALARM_FLAGS_OFS, 8'h05);
        wr(ALARM_FLAGS_OFS, 8'hFF);
        rd(ALARM_FLAGS_OFS, 8'h00);
        // each overflow flag, its gate and its clear
        for (int i = 0; i < 8; i++)
        begin
            m = 8'h01 << i;
            @(posedge core_clk);
            cntOvfLo <= m;
            @(posedge core_clk);
            cntOvfLo <= 8'h00;
            rd(PM_FLAGS_LO_OFS, m);
            irqChk(1'b1);
            wr(PM_IRQ_EN_LO_OFS, m);
            rd(PM_IRQ_EN_LO_OFS, m);
            irqChk(1'b0);
            wr(PM_FLAGS_LO_OFS, ~m);
            rd(PM_FLAGS_LO_OFS, m);
            wr(PM_FLAGS_LO_OFS, m);
            rd(PM_FLAGS_LO_OFS, 8'h00);
            irqChk(1'b1);
            wr(PM_IRQ_EN_LO_OFS, 8'h00);
        end
        // line-code overflow flag and gate
        @(posedge core_clk);
        cntOvfLcv <= 1'b1;
        @(posedge core_clk);
        cntOvfLcv <= 1'b0;
        rd(PM_FLAGS_HI_OFS, 8'h01);
        irqChk(1'b1);
        wr(PM_IRQ_EN_HI_OFS, 8'h01);
        irqChk(1'b0);
        wr(PM_FLAGS_HI_OFS, 8'h01);
        rd(PM_FLAGS_HI_OFS, 8'h00);
        irqChk(1'b1);
        // manual snapshot only on a rising trigger
        s = snapCnt;
        wr(PM_UPD_CTRL_OFS, 8'h02);
        repeat (3) @(posedge core_clk);
        check(8'(snapCnt - s), 8'h01);
        wr(PM_UPD_CTRL_OFS, 8'h02);
        repeat (3) @(posedge core_clk);
        check(8'(snapCnt - s), 8'h01);
        wr(PM_UPD_CTRL_OFS, 8'h00);
        wr(PM_UPD_CTRL_OFS, 8'h02);
        repeat (3) @(posedge core_clk);
        check(8'(snapCnt - s), 8'h02);
        // periodic snapshot on and off
        s = snapCnt;
        wr(PM_UPD_CTRL_OFS, 8'h01);
        repeat (2 * SNAP_T + 20) @(posedge core_clk);
        check(8'(snapCnt - s), 8'h02);
        wr(PM_UPD_CTRL_OFS, 8'h00);
        s = snapCnt;
        repeat (2 * SNAP_T + 20) @(posedge core_clk);
        check(8'(snapCnt - s), 8'h00);
        wrapUp();
    end

endmodule : test_e1_alarm_perfmon_event_regs

`default_nettype wire
